// file: rtl/tsi_trigger_unit.sv
/*
  tsi_trigger_unit: trigger source selection, slope/polarity qualification, manual force and
  internal interval generator, with an APB register slave.
  Assumes the external trigger input is already the digital result of the level comparator,
  busy_i comes from the run-mode sequencer, and force_button_i is a debounced level.
*/
// Design decisions made here: register access over APB and the placing of the registers.
// Functional notes
// - Source setting offers only external input or internal periodic generator.
// - External source: trigger events come only from the external input or a force.
// - Internal source: only interval configurable; gated mode gets no internal triggers.
// - Slope picks rising or falling edge; in gated mode it sets polarity.
// - Gated mode: trigger asserted while qualified input is at or above threshold.
// - Internal generator pulses once per interval, 1.0 us up to 10.0 s.
// - Interval count starts at the run command; first pulse one interval later.
// - Manual force makes a trigger at once, whatever the source.
// - Force leaves the interval timer and its schedule untouched.
// - External source disables periodic triggers; only external or force remain.
// - Triggered and enhanced modes ignore external edges and forces while output is in progress.
// - Gated output follows trigger true or force held, stops when both drop.
`timescale 1ns/1ps
module tsi_trigger_unit #(
  parameter int unsigned CYC_PER_US = tsi_pkg::CYC_PER_US,
  parameter int unsigned INTERVAL_MAX_US = tsi_pkg::INTERVAL_MAX_US
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // register bus
  input wire tsi_pkg::tsi_apb_req_t apb_req_i,
  output tsi_pkg::tsi_apb_rsp_t apb_rsp_o,
  // trigger sources
  input wire logic external_trigger_input_i,
  input wire logic force_button_i,
  // run-mode sequencer
  input wire logic busy_i,
  output logic trig_pulse_o,
  output logic gate_o,
  output logic running_o
);
  import tsi_pkg::*;

  typedef enum logic {
    TSI_ST_STOPPED,
    TSI_ST_RUN
  } tsi_state_t;

  localparam logic [INTERVAL_W-1:0] IV_MIN = INTERVAL_W'(INTERVAL_MIN_US);
  localparam logic [INTERVAL_W-1:0] IV_MAX = INTERVAL_W'(INTERVAL_MAX_US);

  function automatic logic reg_mapped(input logic [11:0] a);
    reg_mapped = (a == OFS_CTRL) || (a == OFS_INTERVAL) || (a == OFS_STATUS) ||
                 (a == OFS_CMD) || (a == OFS_TRIGCNT);
  endfunction : reg_mapped

  function automatic logic [INTERVAL_W-1:0] clamp_iv(input logic [31:0] v);
    if (v < 32'(IV_MIN)) begin
      clamp_iv = IV_MIN;
    end else if (v > 32'(IV_MAX)) begin
      clamp_iv = IV_MAX;
    end else begin
      clamp_iv = v[INTERVAL_W-1:0];
    end
  endfunction : clamp_iv

  // reset release
  logic rst_s1_q;
  logic rst_n;

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_s1_q <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n <= rst_s1_q;
    end
  end

  // external input synchroniser and edge history
  logic ext_s1_q;
  logic ext_s2_q;
  logic ext_s3_q;

  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      ext_s1_q <= 1'b0;
      ext_s2_q <= 1'b0;
      ext_s3_q <= 1'b0;
    end else begin
      ext_s1_q <= external_trigger_input_i;
      ext_s2_q <= ext_s1_q;
      ext_s3_q <= ext_s2_q;
    end
  end

  logic frc_btn_q;

  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      frc_btn_q <= 1'b0;
    end else begin
      frc_btn_q <= force_button_i;
    end
  end

  // register bus
  tsi_cfg_t cfg_q;
  logic [INTERVAL_W-1:0] interval_q;
  logic [31:0] prdata_q;
  logic pslverr_q;
  logic apb_setup;
  logic apb_access;
  logic wr_en;
  logic cmd_run;
  logic cmd_stop;
  logic cmd_force;
  logic iv_wr;

  assign apb_setup = apb_req_i.psel && !apb_req_i.penable;
  assign apb_access = apb_req_i.psel && apb_req_i.penable;
  assign wr_en = apb_access && apb_req_i.pwrite && reg_mapped(apb_req_i.paddr);
  assign cmd_run = wr_en && (apb_req_i.paddr == OFS_CMD) && apb_req_i.pwdata[CMD_RUN_BIT];
  assign cmd_stop = wr_en && (apb_req_i.paddr == OFS_CMD) && apb_req_i.pwdata[CMD_STOP_BIT];
  assign cmd_force = wr_en && (apb_req_i.paddr == OFS_CMD) && apb_req_i.pwdata[CMD_FORCE_BIT];
  assign iv_wr = wr_en && (apb_req_i.paddr == OFS_INTERVAL);

  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      cfg_q <= CFG_RST;
    end else if (wr_en && (apb_req_i.paddr == OFS_CTRL)) begin
      cfg_q.src_int <= apb_req_i.pwdata[CTRL_SRC_BIT];
      cfg_q.slope_fall <= apb_req_i.pwdata[CTRL_SLOPE_BIT];
      cfg_q.mode <= tsi_mode_t'(apb_req_i.pwdata[CTRL_MODE_LSB +: 2]);
    end
  end

  // out-of-range intervals are clamped rather than refused, so software always reads what runs
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      interval_q <= INTERVAL_RST;
    end else if (iv_wr) begin
      interval_q <= clamp_iv(apb_req_i.pwdata);
    end
  end

  // run state
  tsi_state_t state_q;
  logic run;

  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= TSI_ST_STOPPED;
    end else begin
      case (state_q)
        TSI_ST_STOPPED: begin
          if (cmd_run) begin
            state_q <= TSI_ST_RUN;
          end
        end
        TSI_ST_RUN: begin
          if (cmd_stop && !cmd_run) begin
            state_q <= TSI_ST_STOPPED;
          end
        end
        default: begin
          state_q <= TSI_ST_STOPPED;
        end
      endcase
    end
  end

  assign run = (state_q == TSI_ST_RUN);

  // interval generator: restarted only by the run command
  logic tick;

  tsi_interval_timer #(
    .CYC_PER_US(CYC_PER_US),
    .IW(INTERVAL_W)
  ) u_timer (
    .clk_i(clk_sys_i),
    .rst_n_i(rst_n),
    .start_i(cmd_run),
    .en_i(run),
    .interval_i(interval_q),
    .tick_o(tick)
  );

  // qualification
  logic ext_lvl;
  logic ext_edge;
  logic force_evt;
  logic edge_mode;
  logic blocked;
  logic int_trig;
  logic ext_trig;
  logic trig_d;
  logic trig_q;
  logic gate_d;
  logic gate_q;

  assign ext_lvl = ext_s2_q ^ cfg_q.slope_fall;
  assign ext_edge = cfg_q.slope_fall ? (ext_s3_q && !ext_s2_q) : (!ext_s3_q && ext_s2_q);
  assign force_evt = cmd_force || (force_button_i && !frc_btn_q);
  assign edge_mode = (cfg_q.mode != TSI_MODE_GATED);
  // enhanced mode is handled like triggered here; sequence-table behaviour lives in the sequencer
  assign blocked = ((cfg_q.mode == TSI_MODE_TRIG) || (cfg_q.mode == TSI_MODE_ENH)) && busy_i;
  assign int_trig = cfg_q.src_int && tick;
  assign ext_trig = !cfg_q.src_int && ext_edge;
  assign trig_d = run && edge_mode && !blocked && (ext_trig || int_trig || force_evt);
  assign gate_d = run && !edge_mode && ((!cfg_q.src_int && ext_lvl) || force_button_i);

  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      trig_q <= 1'b0;
    end else begin
      trig_q <= trig_d;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      gate_q <= 1'b0;
    end else begin
      gate_q <= gate_d;
    end
  end

  // trigger counter, cleared by the run command
  logic [TRIGCNT_W-1:0] trigcnt_q;

  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      trigcnt_q <= '0;
    end else if (cmd_run) begin
      trigcnt_q <= '0;
    end else if (trig_q) begin
      trigcnt_q <= trigcnt_q + 1'b1;
    end
  end

  // read data is captured in the setup cycle so the answer comes with no wait state
  logic [31:0] rd_mux;

  always_comb begin
    rd_mux = 32'h00000000;
    case (apb_req_i.paddr)
      OFS_CTRL: begin
        rd_mux[CTRL_SRC_BIT] = cfg_q.src_int;
        rd_mux[CTRL_SLOPE_BIT] = cfg_q.slope_fall;
        rd_mux[CTRL_MODE_LSB +: 2] = cfg_q.mode;
      end
      OFS_INTERVAL: begin
        rd_mux[INTERVAL_W-1:0] = interval_q;
      end
      OFS_STATUS: begin
        rd_mux[ST_RUN_BIT] = run;
        rd_mux[ST_SRC_BIT] = cfg_q.src_int;
        rd_mux[ST_GATE_BIT] = gate_q;
        rd_mux[ST_LVL_BIT] = ext_lvl;
        rd_mux[ST_BUSY_BIT] = busy_i;
      end
      OFS_TRIGCNT: begin
        rd_mux[TRIGCNT_W-1:0] = trigcnt_q;
      end
      default: begin
        rd_mux = 32'h00000000;
      end
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      prdata_q <= 32'h00000000;
      pslverr_q <= 1'b0;
    end else if (apb_setup) begin
      prdata_q <= apb_req_i.pwrite ? 32'h00000000 : rd_mux;
      pslverr_q <= !reg_mapped(apb_req_i.paddr);
    end
  end

  assign apb_rsp_o.pready = apb_access;
  assign apb_rsp_o.pslverr = apb_access && pslverr_q;
  assign apb_rsp_o.prdata = prdata_q;
  assign trig_pulse_o = trig_q;
  assign gate_o = gate_q;
  assign running_o = run;

  // helper: cycles since the timer schedule was last anchored
  logic [31:0] since_q;
  logic sched_ok_q;

  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      since_q <= 32'h00000000;
      sched_ok_q <= 1'b0;
    end else begin
      since_q <= cmd_run ? 32'h00000000 : (tick ? 32'h00000001 : since_q + 32'h00000001);
      sched_ok_q <= cmd_run || (sched_ok_q && !iv_wr && !cmd_stop);
    end
  end

  a_tick_period: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
    tick && sched_ok_q |-> since_q == 32'(interval_q) * 32'(CYC_PER_US))
    else $error("interval tick off schedule");

  // no tick may come sooner than one microsecond after the run command or the previous tick
  a_start_quiet: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
    tick |-> since_q >= 32'(CYC_PER_US))
    else $error("tick too soon after run command");

  a_busy_blocks: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
    trig_pulse_o && $past(cfg_q.mode == TSI_MODE_TRIG) |-> !$past(busy_i))
    else $error("trigger passed while output busy");

  a_gated_no_pulse: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
    $past(cfg_q.mode == TSI_MODE_GATED) |-> !trig_pulse_o)
    else $error("edge trigger emitted in gated mode");

  a_ext_source_only: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
    trig_pulse_o && !$past(cfg_q.src_int) |-> $past(ext_edge || force_evt))
    else $error("periodic trigger with external source");

  a_edge_to_pulse: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
    run && edge_mode && !blocked && ext_trig |=> trig_pulse_o)
    else $error("qualified edge gave no pulse");

  a_force_now: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
    run && edge_mode && !blocked && cmd_force |=> trig_pulse_o)
    else $error("force gave no pulse");

  a_gate_level: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
    run && !edge_mode && !cfg_q.src_int && (ext_s2_q != cfg_q.slope_fall) |=> gate_o)
    else $error("gate not asserted at active level");

  a_gate_release: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
    !(ext_lvl && !cfg_q.src_int) && !force_button_i |=> !gate_o)
    else $error("gate held without trigger or force");

  a_enh_busy: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
    trig_pulse_o && $past(cfg_q.mode == TSI_MODE_ENH) |-> !$past(busy_i))
    else $error("enhanced trigger passed while output busy");

  a_int_gated: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
    run && !edge_mode && cfg_q.src_int && !force_button_i |=> !gate_o)
    else $error("internal source opened the gate");

  a_btn_gate: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
    run && !edge_mode && force_button_i |=> gate_o)
    else $error("held force did not open the gate");
endmodule : tsi_trigger_unit

// file: rtl/tsi_pkg.sv
/*
  tsi_pkg: constants, modes and bus carriers of the trigger source and interval unit.
  Assumes a 100 MHz system clock and a 32-bit APB register bus.
*/
package tsi_pkg;
  // timing
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned TICK_NS = 1000;
  localparam int unsigned CYC_PER_US = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned INTERVAL_MIN_US = 1;
  localparam int unsigned INTERVAL_MAX_S = 10;
  localparam int unsigned INTERVAL_MAX_US = INTERVAL_MAX_S * 1000000;
  localparam int unsigned INTERVAL_W = 24;
  localparam logic [INTERVAL_W-1:0] INTERVAL_RST = 24'h0003e8;

  // register offsets
  localparam logic [11:0] OFS_CTRL = 12'h000;
  localparam logic [11:0] OFS_INTERVAL = 12'h004;
  localparam logic [11:0] OFS_STATUS = 12'h008;
  localparam logic [11:0] OFS_CMD = 12'h00c;
  localparam logic [11:0] OFS_TRIGCNT = 12'h010;

  // field positions
  localparam int unsigned CTRL_SRC_BIT = 0;
  localparam int unsigned CTRL_SLOPE_BIT = 1;
  localparam int unsigned CTRL_MODE_LSB = 2;
  localparam int unsigned CMD_RUN_BIT = 0;
  localparam int unsigned CMD_STOP_BIT = 1;
  localparam int unsigned CMD_FORCE_BIT = 2;
  localparam int unsigned ST_RUN_BIT = 0;
  localparam int unsigned ST_SRC_BIT = 1;
  localparam int unsigned ST_GATE_BIT = 2;
  localparam int unsigned ST_LVL_BIT = 3;
  localparam int unsigned ST_BUSY_BIT = 4;
  localparam int unsigned TRIGCNT_W = 16;

  typedef enum logic [1:0] {
    TSI_MODE_CONT,
    TSI_MODE_TRIG,
    TSI_MODE_GATED,
    TSI_MODE_ENH
  } tsi_mode_t;

  typedef struct packed {
    tsi_mode_t mode;
    logic slope_fall;
    logic src_int;
  } tsi_cfg_t;

  localparam tsi_cfg_t CFG_RST = '{mode: TSI_MODE_CONT, slope_fall: 1'b0, src_int: 1'b0};

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } tsi_apb_req_t;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } tsi_apb_rsp_t;
endpackage : tsi_pkg

// file: rtl/tsi_interval_timer.sv
/*
  tsi_interval_timer: microsecond prescaler and interval down-counter, one tick pulse per interval.
  Assumes an asynchronous active-low reset already released cleanly, and interval_i of at least 1.
*/
`timescale 1ns/1ps
module tsi_interval_timer #(
  parameter int unsigned CYC_PER_US = tsi_pkg::CYC_PER_US,
  parameter int unsigned IW = tsi_pkg::INTERVAL_W
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // control
  input wire logic start_i,
  input wire logic en_i,
  input wire logic [IW-1:0] interval_i,
  // event
  output logic tick_o
);
  localparam logic [15:0] PRE_LOAD = 16'(CYC_PER_US - 1);

  logic [15:0] pre_q;
  logic [IW-1:0] cnt_q;
  logic tick_q;

  // the reload takes the interval value current at that moment, so a new value applies from the next period
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pre_q <= 16'h0000;
      cnt_q <= '0;
    end else if (start_i) begin
      pre_q <= PRE_LOAD;
      cnt_q <= interval_i - 1'b1;
    end else if (en_i) begin
      if (pre_q == 16'h0000) begin
        pre_q <= PRE_LOAD;
        cnt_q <= (cnt_q == '0) ? interval_i - 1'b1 : cnt_q - 1'b1;
      end else begin
        pre_q <= pre_q - 16'h0001;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tick_q <= 1'b0;
    end else begin
      tick_q <= !start_i && en_i && (pre_q == 16'h0000) && (cnt_q == '0);
    end
  end

  assign tick_o = tick_q;
endmodule : tsi_interval_timer

// file: tb/tsi_far_model.sv
/*
  tsi_far_model: stand-in for the external trigger source and the run-mode sequencer.
  Assumes one clock; the bench sets the trigger level and how long each output run lasts.
*/
`timescale 1ns/1ps
module tsi_far_model (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // bench control
  input wire logic level_i,
  input wire logic [7:0] busy_len_i,
  // towards the unit
  input wire logic trig_pulse_i,
  output logic ext_trig_o,
  output logic busy_o
);
  logic [7:0] busy_cnt_q;

  assign ext_trig_o = level_i;
  assign busy_o = (busy_cnt_q != 8'h00);

  // a pulse during a run is not restarted here, so a leaked pulse shows as an extra count
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      busy_cnt_q <= 8'h00;
    end else if (trig_pulse_i && busy_cnt_q == 8'h00) begin
      busy_cnt_q <= busy_len_i;
    end else if (busy_cnt_q != 8'h00) begin
      busy_cnt_q <= busy_cnt_q - 8'h01;
    end
  end
endmodule : tsi_far_model

// file: tb/tb.sv
/*
  tb: self-checking bench of the trigger unit over APB, with the far-side model.
  Assumes the prescaler is shortened to 2 cycles per microsecond.
*/
`timescale 1ns/1ps
module tb;
  import tsi_pkg::*;
  localparam int unsigned CPU = 2;
  logic clk_sys_i = 1'b0;
  logic rst_n_i = 1'b0;
  tsi_apb_req_t req = '0;
  tsi_apb_rsp_t rsp;
  logic ext_lvl = 1'b0;
  logic btn = 1'b0;
  logic [7:0] busy_len = 8'h00;
  logic ext_trig, busy, trig, gate, running;
  logic [31:0] rd;
  logic err;
  int failures = 0;
  int num_checks = 0;
  int cyc = 0;
  int t0;
  int pq[$];

  always #5 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i) cyc <= cyc + 1;
  // sampled mid-cycle so the registered pulse has settled
  always @(negedge clk_sys_i) if (trig === 1'b1) pq.push_back(cyc);

  tsi_trigger_unit #(.CYC_PER_US(CPU), .INTERVAL_MAX_US(INTERVAL_MAX_US)) u_dut (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .apb_req_i(req), .apb_rsp_o(rsp),
    .external_trigger_input_i(ext_trig), .force_button_i(btn), .busy_i(busy),
    .trig_pulse_o(trig), .gate_o(gate), .running_o(running));
  tsi_far_model u_far (.clk_i(clk_sys_i), .rst_n_i(rst_n_i), .level_i(ext_lvl),
    .busy_len_i(busy_len), .trig_pulse_i(trig), .ext_trig_o(ext_trig), .busy_o(busy));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys_i);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
    @(posedge clk_sys_i);
    req.penable <= 1'b1;
    do begin
      @(posedge clk_sys_i);
      n++;
    end while (rsp.pready !== 1'b1 && n < 20);
    if (n == 20) failures++;
    rd = rsp.prdata;
    err = rsp.pslverr;
    req <= '0;
  endtask : apb

  task automatic idle(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask : idle

  task automatic run_cfg(input logic [31:0] ctrl);
    apb(1'b1, OFS_CTRL, ctrl);
    apb(1'b1, OFS_CMD, 32'h1);
    t0 = cyc + 1;
    pq.delete();
  endtask : run_cfg

  task automatic stop_run();
    apb(1'b1, OFS_CMD, 32'h2);
    idle(2);
    chk(running, 32'h0);
  endtask : stop_run

  task automatic t_regs();
    apb(1'b0, OFS_CTRL, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, OFS_INTERVAL, 32'h0);
    chk(rd, 32'h3e8);
    apb(1'b1, OFS_STATUS, 32'h1f);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 12'h014, 32'h0);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
    apb(1'b1, OFS_INTERVAL, 32'h0);
    apb(1'b0, OFS_INTERVAL, 32'h0);
    chk(rd, 32'h1);
    apb(1'b1, OFS_INTERVAL, 32'hffffff);
    apb(1'b0, OFS_INTERVAL, 32'h0);
    chk(rd, 32'h989680);
  endtask : t_regs

  task automatic t_internal();
    int f;
    apb(1'b1, OFS_INTERVAL, 32'h5);
    run_cfg(32'h1);
    idle(13);
    apb(1'b1, OFS_CMD, 32'h4);
    f = cyc + 1;
    idle(28);
    chk(pq.size(), 32'd5);
    chk(pq[0], t0 + 11);
    chk(pq[1], f);
    chk(pq[2], t0 + 21);
    chk(pq[3] - pq[2], 32'd10);
    apb(1'b0, OFS_TRIGCNT, 32'h0);
    chk(rd, 32'd5);
    stop_run();
  endtask : t_internal

  task automatic t_edge();
    int ta;
    apb(1'b1, OFS_INTERVAL, 32'h1);
    for (int s = 0; s < 2; s++) begin
      ext_lvl <= ~s[0];
      idle(5);
      run_cfg(32'h4 | (32'(s) << 1));
      idle(10);
      ext_lvl <= s[0];
      idle(8);
      ext_lvl <= ~s[0];
      ta = cyc + 1;
      idle(8);
      chk(pq.size(), 32'd1);
      chk(32'(pq[0] - ta < 6), 32'd1);
      stop_run();
    end
  endtask : t_edge

  task automatic t_busy();
    int f;
    busy_len <= 8'd30;
    ext_lvl <= 1'b0;
    run_cfg(32'h4);
    ext_lvl <= 1'b1;
    idle(6);
    ext_lvl <= 1'b0;
    idle(4);
    ext_lvl <= 1'b1;
    idle(6);
    apb(1'b1, OFS_CMD, 32'h4);
    idle(20);
    apb(1'b1, OFS_CMD, 32'h4);
    f = cyc + 1;
    idle(3);
    chk(pq.size(), 32'd2);
    chk(pq[1], f);
    busy_len <= 8'h00;
    stop_run();
  endtask : t_busy

  task automatic t_gated();
    for (int s = 0; s < 2; s++) begin
      ext_lvl <= s[0];
      run_cfg(32'h8 | (32'(s) << 1));
      idle(6);
      chk(gate, 32'h0);
      ext_lvl <= ~s[0];
      idle(6);
      chk(gate, 32'h1);
      ext_lvl <= s[0];
      idle(6);
      chk(gate, 32'h0);
      chk(pq.size(), 32'd0);
    end
    run_cfg(32'h9);
    ext_lvl <= 1'b1;
    idle(10);
    chk(gate, 32'h0);
    chk(pq.size(), 32'd0);
    btn <= 1'b1;
    idle(4);
    chk(gate, 32'h1);
    btn <= 1'b0;
    idle(4);
    chk(gate, 32'h0);
    stop_run();
  endtask : t_gated

  task automatic t_button();
    ext_lvl <= 1'b0;
    run_cfg(32'h4);
    btn <= 1'b1;
    idle(4);
    btn <= 1'b0;
    idle(4);
    chk(pq.size(), 32'd1);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk({31'h0, rd[ST_RUN_BIT]}, 32'h1);
    stop_run();
  endtask : t_button

  // enhanced mode: the first force starts an output run, the next one lands inside it
  task automatic t_enh();
    busy_len <= 8'd30;
    ext_lvl <= 1'b0;
    run_cfg(32'hc);
    apb(1'b1, OFS_CMD, 32'h4);
    apb(1'b1, OFS_CMD, 32'h4);
    idle(3);
    chk(pq.size(), 32'd1);
    busy_len <= 8'h00;
    stop_run();
  endtask : t_enh

  task automatic finish_test();
    if (failures == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : finish_test

  initial begin
    repeat (6) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    repeat (3) @(posedge clk_sys_i);
    t_regs();
    t_internal();
    t_edge();
    t_busy();
    t_gated();
    t_button();
    t_enh();
    finish_test();
  end

  initial begin
    #400000;
    failures++;
    finish_test();
  end
endmodule : tb
